// file: xid_decode.v
// extended instruction decode and execute for the 8-bit core
// What this block does
// - prefix 000110 d a f decodes as xor of work register with file
// - d=0 writes result to work register, d=1 writes back to file
// - a=0 uses access bank, a=1 uses bank select register
// - a=0 with extension enabled and f<=95 means offset from pointer two
// - xor with file updates only negative and zero flags
// - extension active when config bit unprogrammed (high); programmed disables
// - E8/E9 add or subtract 6-bit literal to pointer, one cycle, no flags
// - pointer field 11 selects pointer two and returns afterwards
// - add-and-return takes two cycles, pc loaded from return stack top
// - subtract-and-return takes two cycles, returns, no flags changed
// - 0014 is two-cycle call via work register, no flags
// - call pushes pc+2, loads low from work register, high/upper from latches
// - EB with bit7=0 plus F-word is two-cycle move indexed to absolute
// - EB with bit7=1 plus F-word is two-cycle move indexed to indexed
// - EA stores literal at pointer two then decrements it, one cycle
// - every extended instruction except the 0014 call modifies or indexes through a pointer
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "xid_regs.vh"
module xid_decode (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // configuration
  input wire extensionEnableBit,
  // instruction stream
  input wire [15:0] instrWord,
  input wire instrValid,
  // core state
  input wire [3:0] bankSelectReg,
  input wire [7:0] counterHighLatch,
  input wire [4:0] counterUpperLatch,
  input wire [20:0] programCounter,
  input wire [20:0] topOfReturnStack,
  // data memory
  output reg [11:0] dataAddr,
  output reg dataRead,
  input wire [7:0] dataRdata,
  output reg dataWrite,
  output reg [7:0] dataWdata,
  // results
  output reg [7:0] workingRegister,
  output reg flagNegative,
  output reg flagZero,
  output reg [11:0] pointer0,
  output reg [11:0] pointer1,
  output reg [11:0] pointerTwo,
  output reg pcLoad,
  output reg [20:0] pcValue,
  output reg stackPush,
  output reg [20:0] stackPushValue,
  output reg instrDone,
  output reg unknownOp
);
  // ------------------------------------------------------------
  // phase generator
  // ------------------------------------------------------------
  wire [1:0] phase;
  wire cycleEnd;
  xid_phase uPhase (
    .clk(clk),
    .rst_n(rst_n),
    .phase(phase),
    .cycleEnd(cycleEnd)
  );
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  localparam ST_FIRST = 3'b001;
  localparam ST_SECOND = 3'b010;
  localparam ST_NOP = 3'b100;
  reg [2:0] state;
  reg [15:0] ir;
  reg [11:0] srcAddr;
  reg movIndexed;
  reg [7:0] moveData;
  wire extOn = extensionEnableBit;
  wire isXor = (ir[15:10] == `XID_PFX_XOR_WORK_WITH_FILE);
  wire isAdd = extOn && (ir[15:8] == `XID_OP_ADDPTR);
  wire isSub = extOn && (ir[15:8] == `XID_OP_SUBPTR);
  wire isPush = extOn && (ir[15:8] == `XID_OP_PUSH_LITERAL);
  wire isMovs = extOn && (ir[15:8] == `XID_OP_MOVS);
  wire isCall = extOn && (ir == `XID_OP_CALL_VIA_WORK_REGISTER);
  wire withRet = (ir[7:6] == `XID_PTR_TWO);
  wire xorD = ir[9];
  wire xorA = ir[8];
  wire [7:0] xorF = ir[7:0];
  // address of the xor operand
  reg [11:0] xorAddr;
  always @* begin
    if (!xorA && extOn && (xorF <= `XID_OFFSET_MAX)) begin
      xorAddr = pointerTwo + {4'h0, xorF};
    end else if (!xorA) begin
      // access bank offsets below 60h are in bank 0, offsets from 60h up are in the top bank
      xorAddr = (xorF < `XID_ACCESS_HI) ? {4'h0, xorF} : {`XID_ACCESS_BANK, xorF};
    end else begin
      xorAddr = {bankSelectReg, xorF};
    end
  end
  wire [7:0] xorResult = workingRegister ^ dataRdata;
  wire [11:0] lit6 = {6'h00, ir[5:0]};
  wire [11:0] srcIdx = pointerTwo + {5'h00, ir[6:0]};
  // ------------------------------------------------------------
  // execute
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_FIRST;
      ir <= 16'h0000;
      srcAddr <= `XID_PTR_RST;
      movIndexed <= 1'b0;
      moveData <= 8'h00;
      dataAddr <= `XID_PTR_RST;
      dataRead <= 1'b0;
      dataWrite <= 1'b0;
      dataWdata <= 8'h00;
      workingRegister <= `XID_WORKING_REGISTER_RST;
      flagNegative <= 1'b0;
      flagZero <= 1'b0;
      pointer0 <= `XID_PTR_RST;
      pointer1 <= `XID_PTR_RST;
      pointerTwo <= `XID_PTR_RST;
      pcLoad <= 1'b0;
      pcValue <= 21'h000000;
      stackPush <= 1'b0;
      stackPushValue <= 21'h000000;
      instrDone <= 1'b0;
      unknownOp <= 1'b0;
    end else begin
      dataRead <= 1'b0;
      dataWrite <= 1'b0;
      pcLoad <= 1'b0;
      stackPush <= 1'b0;
      instrDone <= 1'b0;
      unknownOp <= 1'b0;
      case (state)
        ST_FIRST: begin
          // Q1: take the instruction word
          if (phase == 2'h0) begin
            ir <= instrValid ? instrWord : 16'h0000;
          end
          if (phase == `XID_PHASE_READ) begin
            if (isXor) begin
              dataAddr <= xorAddr;
              dataRead <= 1'b1;
            end else if (isMovs) begin
              srcAddr <= srcIdx;
              dataAddr <= srcIdx;
              dataRead <= 1'b1;
            end
          end
          if (phase == `XID_PHASE_WRITE) begin
            if (isXor) begin
              flagNegative <= xorResult[7];
              flagZero <= (xorResult == 8'h00);
              if (xorD) begin
                dataWrite <= 1'b1;
                dataWdata <= xorResult;
              end else begin
                workingRegister <= xorResult;
              end
              instrDone <= 1'b1;
            end else if (isAdd || isSub) begin
              // pointer arithmetic, plus the return when the pointer field is 11; flags untouched
              case (ir[7:6])
                2'h0: pointer0 <= isAdd ? pointer0 + lit6 : pointer0 - lit6;
                2'h1: pointer1 <= isAdd ? pointer1 + lit6 : pointer1 - lit6;
                default: pointerTwo <= isAdd ? pointerTwo + lit6 : pointerTwo - lit6;
              endcase
              if (withRet) begin
                pcLoad <= 1'b1;
                pcValue <= topOfReturnStack;
                state <= ST_NOP;
              end else begin
                instrDone <= 1'b1;
              end
            end else if (isPush) begin
              dataAddr <= pointerTwo;
              dataWrite <= 1'b1;
              dataWdata <= ir[7:0];
              pointerTwo <= pointerTwo - 12'h001;
              instrDone <= 1'b1;
            end else if (isCall) begin
              stackPush <= 1'b1;
              stackPushValue <= programCounter + `XID_PC_STEP;
              pcLoad <= 1'b1;
              pcValue <= {counterUpperLatch, counterHighLatch, workingRegister};
              state <= ST_NOP;
            end else if (isMovs) begin
              // read data only stand in the cycle after the read strobe
              moveData <= dataRdata;
              movIndexed <= ir[7];
              state <= ST_SECOND;
            end else begin
              // word outside this block's share of the set; an all-zero word is an idle slot
              unknownOp <= |ir;
              instrDone <= 1'b1;
            end
          end
        end
        ST_SECOND: begin
          if (phase == 2'h0) begin
            ir <= instrWord;
          end
          if (phase == `XID_PHASE_WRITE) begin
            // a broken second word leaves memory untouched
            if (ir[15:12] == `XID_OP_SECOND) begin
              dataAddr <= movIndexed ? pointerTwo + {5'h00, ir[6:0]} : ir[11:0];
              dataWrite <= 1'b1;
              dataWdata <= moveData;
            end else begin
              unknownOp <= 1'b1;
            end
            instrDone <= 1'b1;
            state <= ST_FIRST;
          end
        end
        ST_NOP: begin
          // second cycle is a no-operation while the new target is fetched
          if (cycleEnd) begin
            instrDone <= 1'b1;
            state <= ST_FIRST;
          end
        end
        default: begin
          state <= ST_FIRST;
        end
      endcase
    end
  end
endmodule // xid_decode
`default_nettype wire

// file: xid_decode_properties.sv
// assertion checker for the extended instruction decode block
`timescale 1ns/1ps
`default_nettype none
module xid_decode_chk (
  // clock, reset and core inputs
  input wire clk,
  input wire rst_n,
  input wire extensionEnableBit,
  input wire [7:0] counterHighLatch,
  input wire [4:0] counterUpperLatch,
  input wire [20:0] programCounter,
  input wire [20:0] topOfReturnStack,
  // results
  input wire dataRead,
  input wire dataWrite,
  input wire [7:0] workingRegister,
  input wire flagNegative,
  input wire flagZero,
  input wire [11:0] pointer0,
  input wire [11:0] pointer1,
  input wire [11:0] pointerTwo,
  input wire pcLoad,
  input wire [20:0] pcValue,
  input wire stackPush,
  input wire [20:0] stackPushValue,
  input wire instrDone,
  input wire unknownOp
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the bound leaves room for a two-cycle move
  sequence s_finish;
    ##[1:8] instrDone;
  endsequence
  chk_done_spacing: assert property (instrDone |=> (!instrDone) [*3])
    else $error("done pulses too close");
  chk_flags_on_done: assert property ($changed({flagNegative, flagZero}) |-> instrDone)
    else $error("flags moved outside completion");
  chk_pc_source: assert property (pcLoad |-> pcValue == topOfReturnStack || pcValue == {counterUpperLatch, counterHighLatch, workingRegister})
    else $error("pc loaded from wrong source");
  chk_push_value: assert property (stackPush |-> stackPushValue == programCounter + 21'h000002)
    else $error("wrong return address pushed");
  chk_push_then_load: assert property (stackPush |-> ##[0:4] pcLoad)
    else $error("call pushed but never jumped");
  chk_ext_off_ptrs: assert property ((!extensionEnableBit) [*5] |-> $stable({pointer0, pointer1, pointerTwo}))
    else $error("pointer moved while extension off");
  chk_read_finish: assert property (dataRead |-> s_finish)
    else $error("read not followed by completion");
  chk_unknown_quiet: assert property (unknownOp |-> !dataWrite && !pcLoad && !stackPush)
    else $error("refused word had a side effect");
endmodule // xid_decode_chk
bind xid_decode xid_decode_chk i_chk (.clk, .rst_n, .extensionEnableBit, .counterHighLatch,
  .counterUpperLatch, .programCounter, .topOfReturnStack, .dataRead, .dataWrite,
  .workingRegister, .flagNegative, .flagZero, .pointer0, .pointer1, .pointerTwo, .pcLoad,
  .pcValue, .stackPush, .stackPushValue, .instrDone, .unknownOp);
`default_nettype wire

// file: xid_decode_test.sv
// self-checking bench for the extended instruction decode block
`timescale 1ns/1ps
`default_nettype none
module xid_decode_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic extensionEnableBit = 1'b1;
  logic instrValid = 1'b1;
  logic [15:0] instrWord = 16'hE800;
  logic [3:0] bankSelectReg = 4'h0;
  logic [7:0] counterHighLatch = 8'h00;
  logic [4:0] counterUpperLatch = 5'h00;
  logic [20:0] programCounter = 21'h000000;
  logic [20:0] topOfReturnStack = 21'h000000;
  logic [7:0] dataRdata = 8'h00;
  logic [11:0] dataAddr, pointer0, pointer1, pointerTwo, wA;
  logic [7:0] dataWdata, workingRegister, wD, w = 8'h00;
  logic [20:0] pcValue, stackPushValue, pcV, spV;
  logic dataRead, dataWrite, flagNegative, flagZero, pcLoad, stackPush, instrDone, unknownOp;
  logic [11:0] p [3] = '{12'h000, 12'h000, 12'h000};
  int n_fail = 0, checked = 0, nW = 0, nU = 0, eW = 0, eU = 0;

  xid_decode i_xid_decode (.clk, .rst_n, .extensionEnableBit, .instrWord, .instrValid,
    .bankSelectReg, .counterHighLatch, .counterUpperLatch, .programCounter,
    .topOfReturnStack, .dataAddr, .dataRead, .dataRdata, .dataWrite, .dataWdata,
    .workingRegister, .flagNegative, .flagZero, .pointer0, .pointer1, .pointerTwo, .pcLoad,
    .pcValue, .stackPush, .stackPushValue, .instrDone, .unknownOp);

  initial forever #4 clk = ~clk;

  function automatic logic [7:0] memv(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5A;
  endfunction
  function automatic logic [11:0] xaddr(input logic [7:0] f, input logic a);
    if (a) return {bankSelectReg, f};
    if (extensionEnableBit && f <= 8'h5F) return p[2] + f;
    return {(f < 8'h60) ? 4'h0 : 4'hF, f};
  endfunction

  // ----
  // memory and capture
  // ----
  // read data is only promised the cycle after a read, so it toggles otherwise
  always @(posedge clk) begin
    dataRdata <= dataRead ? memv(dataAddr) : ~dataRdata;
  end
  // pulses are taken mid-cycle so a compare right after the edge sees them
  always @(negedge clk) begin
    if (dataWrite) begin
      wA <= dataAddr;
      wD <= dataWdata;
      nW <= nW + 1;
    end
    if (pcLoad) pcV <= pcValue;
    if (stackPush) spV <= stackPushValue;
    if (unknownOp) nU <= nU + 1;
  end

  task cmp(input string n, input logic [20:0] e, input logic [20:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // entered on a phase-0 edge; a spare frame lets the results land
  task op(input logic [15:0] a, input logic [15:0] b, input logic two);
    instrWord <= a;
    instrValid <= 1'b1;
    repeat (4) @(posedge clk);
    if (two) begin
      instrWord <= b;
      instrValid <= |b;
      repeat (4) @(posedge clk);
    end
    instrValid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task cmpPtr;
    cmp("pointer0", p[0], pointer0);
    cmp("pointer1", p[1], pointer1);
    cmp("pointerTwo", p[2], pointerTwo);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    logic [7:0] f, k, r;
    logic [11:0] d12;
    logic [20:0] t;
    logic [1:0] s;
    logic d, a, sub;
    int i, j;
    i = $urandom(87425);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 16 && instrDone !== 1'b1; i++) @(posedge clk);
    if (i == 16) begin
      n_fail++;
      summarize();
    end
    for (i = 0; i < 24; i++) begin
      f = (i < 2) ? 8'h5F + i[7:0] : $urandom;
      a = (i < 2) ? 1'b0 : $urandom;
      d = $urandom;
      bankSelectReg <= $urandom;
      op({6'h06, d, a, f}, 16'h0000, 1'b0);
      r = w ^ memv(xaddr(f, a));
      if (d) begin
        cmp("writeAddr", xaddr(f, a), wA);
        cmp("writeData", r, wD);
        eW++;
      end
      else w = r;
      cmp("work", w, workingRegister);
      cmp("flags", {r[7], r == 8'h00}, {flagNegative, flagZero});
    end
    for (i = 0; i < 12; i++) begin
      s = $urandom;
      k = $urandom & 8'h3F;
      sub = $urandom;
      t = $urandom;
      topOfReturnStack <= t;
      op({7'h74, sub, s, k[5:0]}, 16'h0000, s == 2'h3);
      j = (s == 2'h3) ? 2 : s;
      p[j] = sub ? p[j] - k : p[j] + k;
      if (s == 2'h3) cmp("return", t, pcV);
      cmpPtr();
    end
    for (i = 0; i < 6; i++) begin
      k = $urandom;
      d12 = $urandom;
      op({8'hEA, k}, 16'h0000, 1'b0);
      cmp("pushAddr", p[2], wA);
      cmp("pushData", k, wD);
      p[2]--;
      op({8'hEB, 1'b0, k[6:0]}, {4'hF, d12}, 1'b1);
      cmp("absAddr", d12, wA);
      cmp("absData", memv(p[2] + k[6:0]), wD);
      op({8'hEB, 1'b1, k[6:0]}, {4'hF, d12}, 1'b1);
      cmp("idxAddr", p[2] + d12[6:0], wA);
      cmp("idxData", memv(p[2] + k[6:0]), wD);
      eW += 3;
    end
    cmpPtr();
    t = $urandom;
    programCounter <= t;
    counterHighLatch <= k;
    counterUpperLatch <= 5'h15;
    op(16'h0014, 16'h0000, 1'b1);
    cmp("pushed", t + 21'h000002, spV);
    cmp("callTarget", {5'h15, k, w}, pcV);
    op(16'hEB05, 16'h1234, 1'b1);
    extensionEnableBit <= 1'b0;
    op(16'hE805, 16'h0000, 1'b0);
    eU += 2;
    cmpPtr();
    op(16'h1810, 16'h0000, 1'b0);
    w = w ^ memv(12'h010);
    cmp("bankZero", w, workingRegister);
    cmp("writes", eW, nW);
    cmp("refused", eU, nU);
    summarize();
  end
endmodule // xid_decode_test
`default_nettype wire

// file: xid_phase.v
// four-phase instruction clock generator
`timescale 1ns/1ps
`default_nettype none
`include "xid_regs.vh"
module xid_phase (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // phase outputs
  output reg [1:0] phase,
  output wire cycleEnd
);
  assign cycleEnd = (phase == `XID_PHASE_LAST);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
endmodule // xid_phase
`default_nettype wire

// file: xid_regs.vh
// constants for the extended instruction decode block
`ifndef XID_REGS_VH
`define XID_REGS_VH
`define XID_PFX_XOR_WORK_WITH_FILE 6'h06
`define XID_OP_ADDPTR 8'hE8
`define XID_OP_SUBPTR 8'hE9
`define XID_OP_PUSH_LITERAL 8'hEA
`define XID_OP_MOVS 8'hEB
`define XID_OP_CALL_VIA_WORK_REGISTER 16'h0014
`define XID_OP_SECOND 4'hF
`define XID_OFFSET_MAX 8'h5F
`define XID_PTR_TWO 2'h3
`define XID_PHASE_LAST 2'h3
`define XID_PHASE_READ 2'h1
`define XID_PHASE_WRITE 2'h3
`define XID_ACCESS_HI 8'h60
`define XID_ACCESS_BANK 4'hF
`define XID_PC_STEP 21'h000002
`define XID_PTR_RST 12'h000
`define XID_WORKING_REGISTER_RST 8'h00
`endif
